/* plloc_chk_sva.sv */
// Checker for plloc_top: oscillator enables, PLL lock and bus answers seen at the top ports.
// Assumes one clock domain; bound to every plloc_top instance by the statement at the foot.
`timescale 1ns/1ns
module plloc_chk (
	input wire logic CLK,
	input wire logic RST_N,
	input wire logic HREADYOUT,
	input wire logic HRESP,
	input wire logic SLEEP,
	input wire logic WDT_EN,
	input wire logic FAIL_MON_EN,
	input wire logic [2:0] SYSCLK_SEL,
	input wire logic POSC_EN,
	input wire logic FRC_EN,
	input wire logic SOSC_EN,
	input wire logic SLOW_INTERNAL_RC_EN,
	input wire logic PLL_EN,
	input wire logic PLL_IN_POSC,
	input wire logic [2:0] PLL_MULT,
	input wire logic PLL_LOCKED
);
	default clocking @(posedge CLK); endclocking
	default disable iff (!RST_N);
	a_bus_okay: assert property (HREADYOUT && !HRESP) else $error("bus answer not zero-wait OKAY");
	a_pll_mult: assert property (PLL_MULT == 3'h4) else $error("PLL multiplier not four");
	a_lock_off: assert property ((!PLL_EN && !SLEEP)[*3] |-> !PLL_LOCKED) else $error("lock without PLL");
	a_posc_pll: assert property ((SYSCLK_SEL == 3'h3 && !SLEEP)[*3] |-> PLL_EN && PLL_IN_POSC)
		else $error("primary PLL source not enabled");
	a_frc_pll: assert property ((SYSCLK_SEL == 3'h1 && !SLEEP)[*3] |-> PLL_EN && !PLL_IN_POSC)
		else $error("fast RC PLL source not enabled");
	a_frc_on: assert property ((SYSCLK_SEL == 3'h0 && !SLEEP)[*3] |-> FRC_EN) else $error("fast RC off");
	a_sosc_sys: assert property ((SYSCLK_SEL == 3'h4 && !SLEEP)[*3] |-> SOSC_EN) else $error("secondary off");
	a_sleep_stop: assert property (SLEEP[*2] |-> !POSC_EN && !FRC_EN) else $error("source runs in Sleep");
	a_slow_internal_rc_keep: assert property ((!SLEEP && (WDT_EN || FAIL_MON_EN || SYSCLK_SEL == 3'h5))[*3] |-> SLOW_INTERNAL_RC_EN)
		else $error("slow RC off while needed");
	a_sleep_slow_internal_rc: assert property ((SLEEP && $stable(WDT_EN))[*2] |-> SLOW_INTERNAL_RC_EN == WDT_EN)
		else $error("slow RC in Sleep not following watchdog");
	c_posc_lock: cover property (SYSCLK_SEL == 3'h3 && PLL_LOCKED);
	c_sleep_wdt: cover property (SLEEP && WDT_EN && SLOW_INTERNAL_RC_EN);
	c_sosc_sys: cover property (SYSCLK_SEL == 3'h4 && SOSC_EN);
endmodule

bind plloc_top plloc_chk u_chk (.CLK(CLK), .RST_N(RST_N), .HREADYOUT(HREADYOUT), .HRESP(HRESP), .SLEEP(SLEEP),
	.WDT_EN(WDT_EN), .FAIL_MON_EN(FAIL_MON_EN), .SYSCLK_SEL(SYSCLK_SEL), .POSC_EN(POSC_EN), .FRC_EN(FRC_EN),
	.SOSC_EN(SOSC_EN), .SLOW_INTERNAL_RC_EN(SLOW_INTERNAL_RC_EN), .PLL_EN(PLL_EN), .PLL_IN_POSC(PLL_IN_POSC), .PLL_MULT(PLL_MULT),
	.PLL_LOCKED(PLL_LOCKED));

/* plloc_pkg.sv */
// Constants, register map and source codes for the PLL lock and oscillator enable control block.
// Assumes a single 10 MHz clock; all oscillator ticks arrive as synchronous one-cycle pulses.
package plloc_pkg;
	localparam logic [7:0] ADDR_OSC_CTRL = 8'h00;
	localparam logic [7:0] ADDR_PLL_SETTLE = 8'h04;
	localparam logic [7:0] ADDR_FAST_RC_TRIM = 8'h08;
	localparam logic [7:0] ADDR_CLK_STATUS = 8'h0C;

	localparam int CUR_LSB = 12;
	localparam int NEXT_LSB = 8;
	localparam int LOCK_BIT = 5;
	localparam int KEEP_ON_BIT = 1;
	localparam int SWITCH_BIT = 0;
	localparam int TRIM_W = 6;
	localparam int SETTLE_W = 16;
	localparam int STAT_CFG_LSB = 8;
	localparam int STAT_POWERUP_TIMER_LSB = 12;

	localparam logic [15:0] SETTLE_RESET = 16'h0100;
	localparam logic [5:0] TRIM_RESET = 6'h00;
	localparam logic [2:0] PLL_MULT = 3'h4;
	localparam logic [9:0] XTAL_LAST = 10'h3FF;

	localparam logic [2:0] SRC_FRC = 3'b000;
	localparam logic [2:0] SRC_FRC_PLL = 3'b001;
	localparam logic [2:0] SRC_POSC = 3'b010;
	localparam logic [2:0] SRC_POSC_PLL = 3'b011;
	localparam logic [2:0] SRC_SOSC = 3'b100;
	localparam logic [2:0] SRC_SLOW_INTERNAL_RC = 3'b101;
	localparam logic [2:0] SRC_FRC_DIV16 = 3'b110;
	localparam logic [2:0] SRC_FRC_DIVN = 3'b111;

	typedef enum logic [1:0] {SW_IDLE, SW_WAIT_SRC, SW_WAIT_LOCK} plloc_sw_t;

	function automatic logic uses_pll(input logic [2:0] s);
		uses_pll = (s == SRC_FRC_PLL) || (s == SRC_POSC_PLL);
	endfunction

	function automatic logic uses_posc(input logic [2:0] s);
		uses_posc = (s == SRC_POSC) || (s == SRC_POSC_PLL);
	endfunction

	function automatic logic uses_frc(input logic [2:0] s);
		uses_frc = (s == SRC_FRC) || (s == SRC_FRC_PLL) || (s == SRC_FRC_DIV16) || (s == SRC_FRC_DIVN);
	endfunction
endpackage

/* plloc_top.sv */
// PLL lock tracking, oscillator enables and source switch sequencing, with an AHB-Lite register slave.
// Assumes fuse words, Sleep, watchdog and monitor enables and oscillator ticks are synchronous to CLK.
`timescale 1ns/1ns

module plloc_xtal_cnt (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic en,
	input wire logic tick,
	output logic ready
);
	logic [9:0] cnt_r;
	logic [9:0] cnt_nxt;
	logic rdy_r;
	logic rdy_nxt;

	// Restarts every time the oscillator is disabled, so wake-up recounts
	always_comb begin
		cnt_nxt = cnt_r;
		rdy_nxt = rdy_r;
		if (!en) begin
			cnt_nxt = '0;
			rdy_nxt = 1'b0;
		end else if (!rdy_r && tick) begin
			if (cnt_r == plloc_pkg::XTAL_LAST) begin
				rdy_nxt = 1'b1;
			end else begin
				cnt_nxt = cnt_r + 10'h001;
			end
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cnt_r <= '0;
			rdy_r <= 1'b0;
		end else begin
			cnt_r <= cnt_nxt;
			rdy_r <= rdy_nxt;
		end
	end

	assign ready = rdy_r;
endmodule

module plloc_top (
	input wire logic CLK,
	input wire logic RST_N,
	input wire logic HSEL,
	input wire logic [31:0] HADDR,
	input wire logic [1:0] HTRANS,
	input wire logic HWRITE,
	input wire logic [2:0] HSIZE,
	input wire logic HREADY,
	input wire logic [31:0] HWDATA,
	output logic [31:0] HRDATA,
	output logic HREADYOUT,
	output logic HRESP,
	input wire logic [2:0] SOURCE_CONFIG_WORD,
	input wire logic [2:0] RESET_CONFIG_WORD,
	input wire logic WDT_EN,
	input wire logic FAIL_MON_EN,
	input wire logic SLEEP,
	input wire logic POSC_TICK,
	input wire logic SOSC_TICK,
	input wire logic POWERUP_TIMER_EXPIRED,
	output logic POSC_EN,
	output logic FRC_EN,
	output logic SOSC_EN,
	output logic SLOW_INTERNAL_RC_EN,
	output logic PLL_EN,
	output logic PLL_IN_POSC,
	output logic [2:0] PLL_MULT,
	output logic [2:0] SYSCLK_SEL,
	output logic SYSCLK_READY,
	output logic PLL_LOCKED,
	output logic [5:0] FAST_RC_TRIM
);
	// Fuse capture
	logic cfg_valid_r;
	logic cfg_valid_nxt;
	logic [2:0] init_src_r;
	logic [2:0] init_src_nxt;
	logic [2:0] powerup_timer_val_r;
	logic [2:0] powerup_timer_val_nxt;

	// Software registers and switch state
	logic [2:0] cur_r;
	logic [2:0] cur_nxt;
	logic [2:0] next_r;
	logic [2:0] next_nxt;
	logic keep_on_r;
	logic keep_on_nxt;
	logic req_r;
	logic req_nxt;
	logic [15:0] settle_len_r;
	logic [15:0] settle_len_nxt;
	logic [5:0] trim_r;
	logic [5:0] trim_nxt;
	plloc_pkg::plloc_sw_t sw_r;
	plloc_pkg::plloc_sw_t sw_nxt;
	logic lock_clr;

	// Lock tracking
	logic lock_r;
	logic lock_nxt;
	logic [15:0] settle_cnt_r;
	logic [15:0] settle_cnt_nxt;
	logic pll_src_r;
	logic pll_src_nxt;

	// Bus slave
	logic wr_pend_r;
	logic wr_pend_nxt;
	logic [7:0] wr_addr_r;
	logic [7:0] wr_addr_nxt;
	logic [31:0] hrdata_nxt;

	// Registered outputs
	logic posc_en_nxt;
	logic frc_en_nxt;
	logic sosc_en_nxt;
	logic slow_internal_rc_en_nxt;
	logic pll_en_nxt;
	logic pll_in_posc_nxt;
	logic ready_nxt;

	logic posc_rdy;
	logic sosc_rdy;
	logic [2:0] tgt;
	logic addr_ph;
	logic [7:0] a_ph;

	assign tgt = (sw_r == plloc_pkg::SW_IDLE) ? cur_r : next_r;
	assign addr_ph = HSEL && HTRANS[1] && HREADY;
	assign a_ph = HADDR[7:0];

	plloc_xtal_cnt u_posc_cnt (
		.clk(CLK),
		.rst_n(RST_N),
		.en(POSC_EN),
		.tick(POSC_TICK),
		.ready(posc_rdy)
	);

	plloc_xtal_cnt u_sosc_cnt (
		.clk(CLK),
		.rst_n(RST_N),
		.en(SOSC_EN),
		.tick(SOSC_TICK),
		.ready(sosc_rdy)
	);

	function automatic logic src_ready(input logic [2:0] s, input logic pr, input logic sr);
		// Fast and slow RC need no start-up count
		src_ready = plloc_pkg::uses_posc(s) ? pr : ((s == plloc_pkg::SRC_SOSC) ? sr : 1'b1);
	endfunction

	// Fuses, control register, switch sequencer
	always_comb begin
		cfg_valid_nxt = 1'b1;
		init_src_nxt = init_src_r;
		powerup_timer_val_nxt = powerup_timer_val_r;
		cur_nxt = cur_r;
		next_nxt = next_r;
		keep_on_nxt = keep_on_r;
		req_nxt = req_r;
		settle_len_nxt = settle_len_r;
		trim_nxt = trim_r;
		sw_nxt = sw_r;
		lock_clr = 1'b0;
		if (!cfg_valid_r) begin
			// Initial source taken from the fuse word right after reset release
			init_src_nxt = SOURCE_CONFIG_WORD;
			powerup_timer_val_nxt = RESET_CONFIG_WORD;
			cur_nxt = SOURCE_CONFIG_WORD;
			next_nxt = SOURCE_CONFIG_WORD;
		end else begin
			if (wr_pend_r) begin
				if (wr_addr_r == plloc_pkg::ADDR_OSC_CTRL) begin
					// Write-protected while a switch is in progress
					if (sw_r == plloc_pkg::SW_IDLE && !req_r) begin
						next_nxt = HWDATA[plloc_pkg::NEXT_LSB +: 3];
						keep_on_nxt = HWDATA[plloc_pkg::KEEP_ON_BIT];
						req_nxt = HWDATA[plloc_pkg::SWITCH_BIT];
					end
				end else if (wr_addr_r == plloc_pkg::ADDR_PLL_SETTLE) begin
					settle_len_nxt = HWDATA[15:0];
				end else if (wr_addr_r == plloc_pkg::ADDR_FAST_RC_TRIM) begin
					trim_nxt = HWDATA[5:0];
				end
			end
			case (sw_r)
				plloc_pkg::SW_IDLE: begin
					if (req_r) begin
						if (next_r == cur_r) begin
							req_nxt = 1'b0;
						end else begin
							sw_nxt = plloc_pkg::SW_WAIT_SRC;
							lock_clr = plloc_pkg::uses_pll(next_r);
						end
					end
				end
				plloc_pkg::SW_WAIT_SRC: begin
					if (src_ready(next_r, posc_rdy, sosc_rdy)) begin
						if (plloc_pkg::uses_pll(next_r)) begin
							sw_nxt = plloc_pkg::SW_WAIT_LOCK;
						end else begin
							cur_nxt = next_r;
							req_nxt = 1'b0;
							sw_nxt = plloc_pkg::SW_IDLE;
						end
					end
				end
				plloc_pkg::SW_WAIT_LOCK: begin
					if (lock_r) begin
						cur_nxt = next_r;
						req_nxt = 1'b0;
						sw_nxt = plloc_pkg::SW_IDLE;
					end
				end
				default: begin
					sw_nxt = plloc_pkg::SW_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			cfg_valid_r <= 1'b0;
			init_src_r <= plloc_pkg::SRC_FRC_DIVN;
			powerup_timer_val_r <= 3'h0;
			cur_r <= plloc_pkg::SRC_FRC_DIVN;
			next_r <= plloc_pkg::SRC_FRC_DIVN;
			keep_on_r <= 1'b0;
			req_r <= 1'b0;
			settle_len_r <= plloc_pkg::SETTLE_RESET;
			trim_r <= plloc_pkg::TRIM_RESET;
			sw_r <= plloc_pkg::SW_IDLE;
		end else begin
			cfg_valid_r <= cfg_valid_nxt;
			init_src_r <= init_src_nxt;
			powerup_timer_val_r <= powerup_timer_val_nxt;
			cur_r <= cur_nxt;
			next_r <= next_nxt;
			keep_on_r <= keep_on_nxt;
			req_r <= req_nxt;
			settle_len_r <= settle_len_nxt;
			trim_r <= trim_nxt;
			sw_r <= sw_nxt;
		end
	end

	// PLL settling counter and lock flag
	always_comb begin
		logic avail;
		logic [15:0] last;
		avail = 1'b0;
		last = 16'h0000;
		pll_src_nxt = (tgt == plloc_pkg::SRC_POSC_PLL);
		lock_nxt = lock_r;
		settle_cnt_nxt = settle_cnt_r;
		avail = PLL_EN && (PLL_IN_POSC ? posc_rdy : 1'b1);
		last = (settle_len_r == 16'h0000) ? 16'h0000 : settle_len_r - 16'h0001;
		if (!plloc_pkg::uses_pll(tgt) || lock_clr || !cfg_valid_r) begin
			lock_nxt = 1'b0;
			settle_cnt_nxt = 16'h0000;
		end else if (!avail || pll_src_nxt != pll_src_r) begin
			lock_nxt = 1'b0;
			settle_cnt_nxt = 16'h0000;
		end else if (!lock_r) begin
			if (settle_cnt_r >= last) begin
				lock_nxt = 1'b1;
			end else begin
				settle_cnt_nxt = settle_cnt_r + 16'h0001;
			end
		end
	end

	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			lock_r <= 1'b0;
			settle_cnt_r <= 16'h0000;
			pll_src_r <= 1'b0;
		end else begin
			lock_r <= lock_nxt;
			settle_cnt_r <= settle_cnt_nxt;
			pll_src_r <= pll_src_nxt;
		end
	end

	// Oscillator enables; both old and new source run during a switch
	always_comb begin
		logic awake;
		awake = cfg_valid_r && !SLEEP;
		posc_en_nxt = awake && (plloc_pkg::uses_posc(cur_r) || plloc_pkg::uses_posc(tgt));
		frc_en_nxt = awake && (plloc_pkg::uses_frc(cur_r) || plloc_pkg::uses_frc(tgt));
		sosc_en_nxt = keep_on_r || (awake && (cur_r == plloc_pkg::SRC_SOSC || tgt == plloc_pkg::SRC_SOSC));
		if (!cfg_valid_r) begin
			slow_internal_rc_en_nxt = 1'b0;
		end else if (SLEEP) begin
			slow_internal_rc_en_nxt = WDT_EN;
		end else begin
			// Slow RC also times the power-up timer, watchdog and clock-fail monitor
			slow_internal_rc_en_nxt = FAIL_MON_EN || WDT_EN || cur_r == plloc_pkg::SRC_SLOW_INTERNAL_RC || tgt == plloc_pkg::SRC_SLOW_INTERNAL_RC
				|| (powerup_timer_val_r != 3'h0 && !POWERUP_TIMER_EXPIRED);
		end
		pll_en_nxt = awake && (plloc_pkg::uses_pll(cur_r) || plloc_pkg::uses_pll(tgt));
		// PLL input stays on the running source until a PLL destination takes over
		pll_in_posc_nxt = plloc_pkg::uses_pll(tgt) ? plloc_pkg::uses_posc(tgt) : plloc_pkg::uses_posc(cur_r);
		ready_nxt = awake && src_ready(cur_r, posc_rdy, sosc_rdy) && (!plloc_pkg::uses_pll(cur_r) || lock_r);
	end

	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			POSC_EN <= 1'b0;
			FRC_EN <= 1'b0;
			SOSC_EN <= 1'b0;
			SLOW_INTERNAL_RC_EN <= 1'b0;
			PLL_EN <= 1'b0;
			PLL_IN_POSC <= 1'b0;
			PLL_MULT <= plloc_pkg::PLL_MULT;
			SYSCLK_SEL <= plloc_pkg::SRC_FRC_DIVN;
			SYSCLK_READY <= 1'b0;
			PLL_LOCKED <= 1'b0;
			FAST_RC_TRIM <= plloc_pkg::TRIM_RESET;
		end else begin
			POSC_EN <= posc_en_nxt;
			FRC_EN <= frc_en_nxt;
			SOSC_EN <= sosc_en_nxt;
			SLOW_INTERNAL_RC_EN <= slow_internal_rc_en_nxt;
			PLL_EN <= pll_en_nxt;
			PLL_IN_POSC <= pll_in_posc_nxt;
			PLL_MULT <= plloc_pkg::PLL_MULT;
			SYSCLK_SEL <= cur_r;
			SYSCLK_READY <= ready_nxt;
			PLL_LOCKED <= lock_r;
			FAST_RC_TRIM <= trim_r;
		end
	end

	// AHB-Lite slave: zero wait states, read data from next-state values so a read right after a write sees it
	always_comb begin
		hrdata_nxt = 32'h0000_0000;
		wr_pend_nxt = addr_ph && HWRITE;
		wr_addr_nxt = a_ph;
		if (addr_ph && !HWRITE) begin
			if (a_ph == plloc_pkg::ADDR_OSC_CTRL) begin
				hrdata_nxt[plloc_pkg::CUR_LSB +: 3] = cur_nxt;
				hrdata_nxt[plloc_pkg::NEXT_LSB +: 3] = next_nxt;
				hrdata_nxt[plloc_pkg::LOCK_BIT] = lock_nxt;
				hrdata_nxt[plloc_pkg::KEEP_ON_BIT] = keep_on_nxt;
				hrdata_nxt[plloc_pkg::SWITCH_BIT] = req_nxt;
			end else if (a_ph == plloc_pkg::ADDR_PLL_SETTLE) begin
				hrdata_nxt[15:0] = settle_len_nxt;
			end else if (a_ph == plloc_pkg::ADDR_FAST_RC_TRIM) begin
				hrdata_nxt[5:0] = trim_nxt;
			end else if (a_ph == plloc_pkg::ADDR_CLK_STATUS) begin
				hrdata_nxt[7:0] = {ready_nxt, sosc_rdy, posc_rdy, pll_en_nxt, slow_internal_rc_en_nxt, sosc_en_nxt,
					frc_en_nxt, posc_en_nxt};
				hrdata_nxt[plloc_pkg::STAT_CFG_LSB +: 3] = init_src_nxt;
				hrdata_nxt[plloc_pkg::STAT_POWERUP_TIMER_LSB +: 3] = powerup_timer_val_nxt;
			end
		end
	end

	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			wr_pend_r <= 1'b0;
			wr_addr_r <= 8'h00;
			HRDATA <= 32'h0000_0000;
			HREADYOUT <= 1'b1;
			HRESP <= 1'b0;
		end else begin
			wr_pend_r <= wr_pend_nxt;
			wr_addr_r <= wr_addr_nxt;
			HRDATA <= hrdata_nxt;
			HREADYOUT <= 1'b1;
			HRESP <= 1'b0;
		end
	end
endmodule

/* plloc_top_tb.sv */
// Self-checking bench for plloc_top: registers, oscillator enables, clock switches, power-on sources.
// Assumes the checker is bound separately; crystal ticks come only while the design enables that crystal.
`timescale 1ns/1ns
module plloc_top_tb;
	logic CLK = 1'b0, RST_N = 1'b0, HSEL = 1'b0, HWRITE = 1'b0, WDT_EN = 1'b0, FAIL_MON_EN = 1'b0, SLEEP = 1'b0;
	logic POSC_TICK = 1'b0, SOSC_TICK = 1'b0, POWERUP_TIMER_EXPIRED = 1'b0;
	logic [31:0] HADDR = 32'h0000_0000, HWDATA = 32'h0000_0000, HRDATA, rd;
	logic [1:0] HTRANS = 2'h0;
	logic [2:0] HSIZE = 3'h2, SOURCE_CONFIG_WORD = 3'h0, RESET_CONFIG_WORD = 3'h3, PLL_MULT, SYSCLK_SEL;
	logic HREADYOUT, HRESP, POSC_EN, FRC_EN, SOSC_EN, SLOW_INTERNAL_RC_EN, PLL_EN, PLL_IN_POSC, SYSCLK_READY, PLL_LOCKED;
	logic [5:0] FAST_RC_TRIM;
	wire logic HREADY;
	int err_total = 0, n_compared = 0, cyc = 0;
	logic [95:0] tb [5] = '{
		{32'h0000_000C, 32'hFFFF_FFFF, 32'h0000_308A},
		{32'h0000_0008, 32'h0000_0017, 32'h0000_0017},
		{32'h0000_0004, 32'h0000_0020, 32'h0000_0020},
		{32'h0000_0010, 32'hFFFF_FFFF, 32'h0000_0000},
		{32'h0000_0000, 32'h0000_0023, 32'h0000_0002}};
	logic [2:0] fz [6] = '{3'h0, 3'h6, 3'h7, 3'h4, 3'h5, 3'h1};

	assign HREADY = HREADYOUT;
	plloc_top dut (.CLK(CLK), .RST_N(RST_N), .HSEL(HSEL), .HADDR(HADDR), .HTRANS(HTRANS), .HWRITE(HWRITE),
		.HSIZE(HSIZE), .HREADY(HREADY), .HWDATA(HWDATA), .HRDATA(HRDATA), .HREADYOUT(HREADYOUT), .HRESP(HRESP),
		.SOURCE_CONFIG_WORD(SOURCE_CONFIG_WORD), .RESET_CONFIG_WORD(RESET_CONFIG_WORD), .WDT_EN(WDT_EN),
		.FAIL_MON_EN(FAIL_MON_EN), .SLEEP(SLEEP), .POSC_TICK(POSC_TICK), .SOSC_TICK(SOSC_TICK),
		.POWERUP_TIMER_EXPIRED(POWERUP_TIMER_EXPIRED), .POSC_EN(POSC_EN), .FRC_EN(FRC_EN), .SOSC_EN(SOSC_EN), .SLOW_INTERNAL_RC_EN(SLOW_INTERNAL_RC_EN),
		.PLL_EN(PLL_EN), .PLL_IN_POSC(PLL_IN_POSC), .PLL_MULT(PLL_MULT), .SYSCLK_SEL(SYSCLK_SEL),
		.SYSCLK_READY(SYSCLK_READY), .PLL_LOCKED(PLL_LOCKED), .FAST_RC_TRIM(FAST_RC_TRIM));

	always #50 CLK = ~CLK;

	always @(posedge CLK) begin
		POSC_TICK <= POSC_EN && !POSC_TICK;
		SOSC_TICK <= SOSC_EN && !SOSC_TICK;
		cyc++;
		if (cyc == 20000) begin
			err_total++;
			wrap_up();
		end
	end

	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		n_compared++;
		if (g !== e) begin
			err_total++;
			$display("BAD %s expected %h seen %h", n, e, g);
		end
	endtask

	task automatic cy(input int n);
		repeat (n) @(posedge CLK);
	endtask

	task automatic ahb(input logic w, input logic [31:0] a, input logic [31:0] d);
		@(posedge CLK);
		HSEL <= 1'b1;
		HTRANS <= 2'h2;
		HADDR <= a;
		HWRITE <= w;
		do @(posedge CLK); while (HREADY !== 1'b1);
		HSEL <= 1'b0;
		HTRANS <= 2'h0;
		HWDATA <= d;
		do @(posedge CLK); while (HREADY !== 1'b1);
		rd = HRDATA;
	endtask

	// Polls the control register until the switch request bit reads back clear
	task automatic wt(input int lim);
		rd = 32'h0000_0001;
		for (int i = 0; i < lim && rd[0] !== 1'b0; i++)
			ahb(1'b0, 32'h0000_0000, 32'h0000_0000);
	endtask

	task automatic rst();
		RST_N <= 1'b0;
		cy(12);
		chk("reset enables", 32'h0000_0000, {27'h000_0000, POSC_EN, FRC_EN, SOSC_EN, SLOW_INTERNAL_RC_EN, PLL_EN});
		chk("reset read data", 32'h0000_0000, HRDATA);
		chk("reset source", 32'h0000_0007, SYSCLK_SEL);
		chk("reset mult", 32'h0000_0004, PLL_MULT);
		RST_N <= 1'b1;
		cy(4);
	endtask

	task automatic wrap_up();
		$display("compared %0d mismatches %0d", n_compared, err_total);
		if (err_total == 0 && n_compared > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	initial begin
		rst();
		ahb(1'b0, 32'h0000_0004, 32'h0000_0000);
		chk("settle reset", 32'h0000_0100, rd);
		chk("slow RC at power-on", 32'h0000_0001, SLOW_INTERNAL_RC_EN);
		for (int i = 0; i < 5; i++) begin
			ahb(1'b1, tb[i][95:64], tb[i][63:32]);
			ahb(1'b0, tb[i][95:64], 32'h0000_0000);
			chk("register", tb[i][31:0], rd);
		end
		chk("trim port", 32'h0000_0017, FAST_RC_TRIM);
		chk("keep-on", 32'h0000_0001, SOSC_EN);
		POWERUP_TIMER_EXPIRED <= 1'b1;
		cy(3);
		chk("slow RC after timer", 32'h0000_0000, SLOW_INTERNAL_RC_EN);
		FAIL_MON_EN <= 1'b1;
		cy(3);
		chk("slow RC for monitor", 32'h0000_0001, SLOW_INTERNAL_RC_EN);
		FAIL_MON_EN <= 1'b0;
		WDT_EN <= 1'b1;
		SLEEP <= 1'b1;
		cy(3);
		chk("Sleep with watchdog", 32'h0000_0003, {FRC_EN, SOSC_EN, SLOW_INTERNAL_RC_EN});
		WDT_EN <= 1'b0;
		cy(3);
		chk("Sleep slow RC", 32'h0000_0000, SLOW_INTERNAL_RC_EN);
		SLEEP <= 1'b0;
		ahb(1'b1, 32'h0000_0000, 32'h0000_0101);
		ahb(1'b0, 32'h0000_0000, 32'h0000_0000);
		chk("switch start", 32'h0000_0101, rd);
		wt(100);
		chk("fast RC PLL", 32'h0000_1120, rd);
		cy(2);
		chk("lock port, secondary off", 32'h0000_0002, {PLL_LOCKED, SOSC_EN});
		ahb(1'b1, 32'h0000_0000, 32'h0000_0201);
		cy(400);
		chk("crystal still starting", 32'h0000_0001, SYSCLK_SEL);
		wt(1000);
		chk("primary", 32'h0000_2200, rd);
		ahb(1'b1, 32'h0000_0000, 32'h0000_0301);
		wt(100);
		chk("primary PLL", 32'h0000_3320, rd);
		ahb(1'b1, 32'h0000_0000, 32'h0000_0401);
		wt(1000);
		chk("secondary", 32'h0000_4400, rd);
		cy(2);
		chk("old sources off", 32'h0000_0002, {POSC_EN, SOSC_EN, PLL_EN});
		ahb(1'b1, 32'h0000_0000, 32'h0000_0501);
		wt(3);
		chk("slow RC at once", 32'h0000_5500, rd);
		cy(2);
		chk("slow RC system", 32'h0000_0001, {SOSC_EN, SLOW_INTERNAL_RC_EN});
		foreach (fz[i]) begin
			SOURCE_CONFIG_WORD <= fz[i];
			rst();
			chk("power-on source", fz[i], SYSCLK_SEL);
			chk("power-on enable", 32'h0000_0001, fz[i] == 3'h4 ? SOSC_EN : fz[i] == 3'h5 ? SLOW_INTERNAL_RC_EN : FRC_EN);
		end
		for (int i = 0; i < 600 && PLL_LOCKED !== 1'b1; i++)
			@(posedge CLK);
		chk("power-on lock", 32'h0000_0001, PLL_LOCKED);
		wrap_up();
	end
endmodule
